// ---- hw/acl_entry_match.sv ----
// Added by the designer: the address map and the APB register port.
`default_nettype none

module acl_entry_match
   import acl_match_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [DATA_W-1:0]   pwdata,
   input  wire logic [STRB_W-1:0]   pstrb,
   output logic      [DATA_W-1:0]   prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                frame_valid,
   input  wire frame_s              frame,
   output logic                     hit_valid,
   output logic                     hit
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      ctrl_s             ctrl;
      logic [PORT_W-1:0] s_lo;
      logic [PORT_W-1:0] s_hi;
      logic [PORT_W-1:0] d_lo;
      logic [PORT_W-1:0] d_hi;
      logic [PORT_W-1:0] etype_val;
      logic              hit;
      logic              hit_valid;
      logic              seen;
   } state_s;

   state_s state_q;
   state_s state_d;

   logic              acc;
   logic              wr;
   logic              addr_ok;
   logic              etype_bad;
   logic              sp_ok;
   logic              dp_ok;
   logic              fl_ok;
   logic              et_ok;
   logic              match;
   logic [DATA_W-1:0] cur_word;
   logic [DATA_W-1:0] new_word;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic port_ok(port_mode_e        m,
                                    logic              l4,
                                    logic [PORT_W-1:0] p,
                                    logic [PORT_W-1:0] lo,
                                    logic [PORT_W-1:0] hi);
      logic r;
      r = 1'b1;
      case (m)
         PORT_EXACT: r = l4 && (p == lo);
         PORT_RANGE: r = l4 && (p >= lo) && (p <= hi);
         default:    r = 1'b1;
      endcase
      return r;
   endfunction

   function automatic logic flag_ok(flag_mode_e m, logic f);
      logic r;
      r = 1'b1;
      case (m)
         FLAG_ZERO: r = !f;
         FLAG_ONE:  r = f;
         default:   r = 1'b1;
      endcase
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] lane_merge(
      logic [DATA_W-1:0] old_w,
      logic [DATA_W-1:0] new_w,
      logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] r;
      r = old_w;
      for (int i = 0; i < STRB_W; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Match terms
   // ----------------------------------------------------------------
   assign sp_ok = port_ok(state_q.ctrl.smode, frame.is_l4, frame.sport,
                          state_q.s_lo, state_q.s_hi);
   assign dp_ok = port_ok(state_q.ctrl.dmode, frame.is_l4, frame.dport,
                          state_q.d_lo, state_q.d_hi);

   logic [N_FLAGS-1:0] flag_each;

   generate
      for (genvar g = 0; g < N_FLAGS; g++)
      begin : g_flag
         assign flag_each[g] = !frame.is_tcp ||
            flag_ok(state_q.ctrl.flags[g], frame.tcp_flags[g]);
      end
   endgenerate

   assign fl_ok = &flag_each;

   assign et_ok = !state_q.ctrl.etype_sel ||
                  !state_q.ctrl.etype_exact ||
                  (frame.etype == state_q.etype_val);

   assign match = sp_ok && dp_ok && fl_ok && et_ok;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign acc     = psel && penable;
   assign wr      = acc && pwrite;
   assign addr_ok = (paddr == CTRL_OFS) || (paddr == SPORT_OFS) ||
                    (paddr == DPORT_OFS) || (paddr == ETYPE_OFS) ||
                    (paddr == STATUS_OFS);

   always_comb
   begin
      cur_word = '0;
      case (paddr)
         CTRL_OFS:   cur_word[CTRL_W-1:0] = state_q.ctrl;
         SPORT_OFS:  cur_word = {state_q.s_hi, state_q.s_lo};
         DPORT_OFS:  cur_word = {state_q.d_hi, state_q.d_lo};
         ETYPE_OFS:  cur_word[PORT_W-1:0] = state_q.etype_val;
         STATUS_OFS:
         begin
            cur_word[ST_HIT]  = state_q.hit;
            cur_word[ST_SEEN] = state_q.seen;
         end
         default:    cur_word = '0;
      endcase
   end

   assign new_word  = lane_merge(cur_word, pwdata, pstrb);
   assign etype_bad = (paddr == ETYPE_OFS) &&
                      (new_word[PORT_W-1:0] < ETYPE_MIN);
   assign prdata    = cur_word;
   assign pready    = 1'b1;
   assign pslverr   = acc && (!addr_ok || (pwrite && etype_bad));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.hit_valid = frame_valid;
      if (frame_valid)
      begin
         state_d.hit  = match;
         state_d.seen = 1'b1;
      end
      if (wr && !etype_bad)
      begin
         case (paddr)
            CTRL_OFS:  state_d.ctrl = ctrl_s'(new_word[CTRL_W-1:0]);
            SPORT_OFS:
            begin
               state_d.s_lo = new_word[LO_LSB +: PORT_W];
               state_d.s_hi = new_word[HI_LSB +: PORT_W];
            end
            DPORT_OFS:
            begin
               state_d.d_lo = new_word[LO_LSB +: PORT_W];
               state_d.d_hi = new_word[HI_LSB +: PORT_W];
            end
            ETYPE_OFS: state_d.etype_val = new_word[PORT_W-1:0];
            default:   state_d.seen = state_d.seen;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q.ctrl      <= ctrl_s'(CTRL_RST);
         state_q.s_lo      <= PORT_RST;
         state_q.s_hi      <= PORT_RST;
         state_q.d_lo      <= PORT_RST;
         state_q.d_hi      <= PORT_RST;
         state_q.etype_val <= ETYPE_RST;
         state_q.hit       <= 1'b0;
         state_q.hit_valid <= 1'b0;
         state_q.seen      <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign hit_valid = state_q.hit_valid;
   assign hit       = state_q.hit;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence hit_seen_s;
      hit_valid && hit;
   endsequence

   sequence miss_seen_s;
      hit_valid && !hit;
   endsequence

   sport_exact_a: assert property (
      hit_seen_s && $past(state_q.ctrl.smode) == PORT_EXACT
      |-> $past(frame.sport) == $past(state_q.s_lo))
      else $error("exact source port hit on other port");

   sport_range_a: assert property (
      hit_seen_s && $past(state_q.ctrl.smode) == PORT_RANGE
      |-> $past(frame.sport) >= $past(state_q.s_lo) &&
          $past(frame.sport) <= $past(state_q.s_hi))
      else $error("source port hit outside range");

   dport_exact_a: assert property (
      hit_seen_s && $past(state_q.ctrl.dmode) == PORT_EXACT
      |-> $past(frame.dport) == $past(state_q.d_lo))
      else $error("exact destination hit on other port");

   dport_range_a: assert property (
      hit_seen_s && $past(state_q.ctrl.dmode) == PORT_RANGE
      |-> $past(frame.dport) >= $past(state_q.d_lo) &&
          $past(frame.dport) <= $past(state_q.d_hi))
      else $error("destination hit outside range");

   range_edge_a: assert property (
      frame_valid && frame.is_l4 && frame.is_tcp == 1'b0 &&
      state_q.ctrl.smode == PORT_RANGE &&
      state_q.ctrl.dmode == PORT_ANY &&
      !state_q.ctrl.etype_sel && frame.sport == state_q.s_lo &&
      state_q.s_lo <= state_q.s_hi
      |=> hit_seen_s)
      else $error("inclusive lower bound missed");

   fin_zero_a: assert property (
      hit_seen_s && $past(frame.is_tcp) &&
      $past(state_q.ctrl.flags[FL_FIN]) == FLAG_ZERO
      |-> !$past(frame.tcp_flags[FL_FIN]))
      else $error("hit with barred FIN");

   syn_one_a: assert property (
      hit_seen_s && $past(frame.is_tcp) &&
      $past(state_q.ctrl.flags[FL_SYN]) == FLAG_ONE
      |-> $past(frame.tcp_flags[FL_SYN]))
      else $error("hit without required SYN");

   rst_zero_a: assert property (
      hit_seen_s && $past(frame.is_tcp) &&
      $past(state_q.ctrl.flags[FL_RST]) == FLAG_ZERO
      |-> !$past(frame.tcp_flags[FL_RST]))
      else $error("hit with barred RST");

   psh_zero_a: assert property (
      hit_seen_s && $past(frame.is_tcp) &&
      $past(state_q.ctrl.flags[FL_PSH]) == FLAG_ZERO
      |-> !$past(frame.tcp_flags[FL_PSH]))
      else $error("hit with barred PSH");

   ack_one_a: assert property (
      hit_seen_s && $past(frame.is_tcp) &&
      $past(state_q.ctrl.flags[FL_ACK]) == FLAG_ONE
      |-> $past(frame.tcp_flags[FL_ACK]))
      else $error("hit without required ACK");

   urg_zero_a: assert property (
      hit_seen_s && $past(frame.is_tcp) &&
      $past(state_q.ctrl.flags[FL_URG]) == FLAG_ZERO
      |-> !$past(frame.tcp_flags[FL_URG]))
      else $error("hit with barred URG");

   etype_eq_a: assert property (
      hit_seen_s && $past(state_q.ctrl.etype_sel) &&
      $past(state_q.ctrl.etype_exact)
      |-> $past(frame.etype) == $past(state_q.etype_val))
      else $error("EtherType hit on other value");

   etype_floor_a: assert property (
      state_q.etype_val >= ETYPE_MIN)
      else $error("stored EtherType below floor");

   all_any_a: assert property (
      frame_valid && state_q.ctrl.smode == PORT_ANY &&
      state_q.ctrl.dmode == PORT_ANY && !state_q.ctrl.etype_sel &&
      !frame.is_tcp
      |=> hit_seen_s)
      else $error("open entry missed a frame");

   verdict_timing_a: assert property (
      frame_valid && !match |=> miss_seen_s ##1 !hit_valid || hit_valid)
      else $error("verdict not one cycle after frame");

   dport_any_a: assert property (
      miss_seen_s && $past(state_q.ctrl.dmode) == PORT_ANY &&
      $past(state_q.ctrl.smode) == PORT_ANY &&
      !$past(state_q.ctrl.etype_sel)
      |-> $past(frame.is_tcp))
      else $error("port-open entry missed a non-TCP frame");

endmodule

`default_nettype wire

// ---- common/acl_match_pkg.sv ----
`default_nettype none

package acl_match_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W   = 12;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned STRB_W   = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
   localparam logic [ADDR_W-1:0] SPORT_OFS  = 12'h004;
   localparam logic [ADDR_W-1:0] DPORT_OFS  = 12'h008;
   localparam logic [ADDR_W-1:0] ETYPE_OFS  = 12'h00c;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h010;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int unsigned PORT_W    = 16;
   localparam int unsigned LO_LSB    = 0;
   localparam int unsigned HI_LSB    = 16;
   localparam int unsigned N_FLAGS   = 6;
   localparam int unsigned CTRL_W    = 18;
   localparam int unsigned ST_HIT    = 0;
   localparam int unsigned ST_SEEN   = 1;
   localparam logic [PORT_W-1:0] ETYPE_MIN = 16'h0600;

   // Flag positions within the TCP flag vector
   localparam int unsigned FL_FIN = 0;
   localparam int unsigned FL_SYN = 1;
   localparam int unsigned FL_RST = 2;
   localparam int unsigned FL_PSH = 3;
   localparam int unsigned FL_ACK = 4;
   localparam int unsigned FL_URG = 5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PORT_ANY   = 2'b00,
      PORT_EXACT = 2'b01,
      PORT_RANGE = 2'b10
   } port_mode_e;

   typedef enum logic [1:0]
   {
      FLAG_ZERO = 2'b00,
      FLAG_ONE  = 2'b01,
      FLAG_ANY  = 2'b10
   } flag_mode_e;

   typedef struct packed
   {
      logic                     etype_sel;
      logic                     etype_exact;
      flag_mode_e [N_FLAGS-1:0] flags;
      port_mode_e               dmode;
      port_mode_e               smode;
   } ctrl_s;

   typedef struct packed
   {
      logic               is_tcp;
      logic               is_l4;
      logic [N_FLAGS-1:0] tcp_flags;
      logic [PORT_W-1:0]  sport;
      logic [PORT_W-1:0]  dport;
      logic [PORT_W-1:0]  etype;
   } frame_s;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST  = 18'h0_aaa0;
   localparam logic [PORT_W-1:0] PORT_RST  = 16'h0000;
   localparam logic [PORT_W-1:0] ETYPE_RST = 16'h0600;

endpackage

`default_nettype wire

// ---- verif/frame_src.sv ----
`default_nettype none

module frame_src
   import acl_match_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rst,
   input  wire logic   send,
   input  wire frame_s send_frame,
   output var  logic   frame_valid,
   output var  frame_s frame
);
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------
   // Header delivery, one cycle per frame
   // ---------------------------------------------
   initial
   begin
      frame_valid = 1'b0;
      frame = '0;
   end

   // Idle header bus keeps toggling, never stale
   always @(posedge clk)
   begin
      frame_valid <= send && !rst;
      frame <= send ? send_frame : ~frame;
   end
endmodule

`default_nettype wire

// ---- verif/acl_entry_match_tb_top.sv ----
`default_nettype none

module acl_entry_match_tb_top
   import acl_match_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] paddr = '0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [STRB_W-1:0] pstrb = 4'hf;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              send = 1'b0;
   frame_s            send_frame = '0;
   logic              frame_valid;
   frame_s            frame;
   logic              hit_valid;
   logic              hit;
   logic              exp_q[$];
   int                err_count = 0;
   int                checks_done = 0;
   int                cycles = 0;

   // ---------------------------------------------
   // Clock, instances, timeout
   // ---------------------------------------------
   initial
   begin
      forever #50 clk = ~clk;
   end

   acl_entry_match acl_entry_match_inst (.clk(clk), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_valid(frame_valid), .frame(frame),
      .hit_valid(hit_valid), .hit(hit));

   frame_src frame_src_inst (.clk(clk), .rst(rst), .send(send),
      .send_frame(send_frame), .frame_valid(frame_valid), .frame(frame));

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         err_count++;
         test_done();
      end
   end

   // ---------------------------------------------
   // Tasks and reference model
   // ---------------------------------------------
   task automatic test_done();
      if (err_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic port_ok(logic [1:0] m, logic [31:0] r,
                                    logic [15:0] p, logic l4);
      if (m == 2'd1)
         return l4 && p == r[15:0];
      if (m == 2'd2)
         return l4 && p >= r[15:0] && p <= r[31:16];
      return 1'b1;
   endfunction

   function automatic logic model(ctrl_s c, logic [31:0] sp,
                                  logic [31:0] dp, logic [15:0] et,
                                  frame_s f);
      logic h;
      h = port_ok(c.smode, sp, f.sport, f.is_l4);
      h &= port_ok(c.dmode, dp, f.dport, f.is_l4);
      for (int i = 0; i < N_FLAGS; i++)
         if (f.is_tcp && (c.flags[i] == FLAG_ZERO && f.tcp_flags[i] ||
             c.flags[i] == FLAG_ONE && !f.tcp_flags[i]))
            h = 1'b0;
      if (c.etype_sel && c.etype_exact && f.etype != et)
         h = 1'b0;
      return h;
   endfunction

   function automatic logic [15:0] pick(logic [31:0] r);
      case ($urandom % 5)
         0: return r[15:0];
         1: return r[31:16];
         2: return r[15:0] - 16'h0001;
         3: return r[31:16] + 16'h0001;
         default: return 16'($urandom);
      endcase
   endfunction

   // ---------------------------------------------
   // Verdict monitor
   // ---------------------------------------------
   always @(posedge clk)
      if (hit_valid === 1'b1)
      begin
         if (exp_q.size() != 0)
            chk(32'(exp_q.pop_front()), 32'(hit));
         else
            chk(32'h0000_0001, 32'h0000_0000);
      end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      ctrl_s       c;
      frame_s      f;
      logic [31:0] sp;
      logic [31:0] dp;
      logic [31:0] rd;
      logic [15:0] et;
      logic [15:0] lo;
      logic        er;
      int          n;
      void'($urandom(32'he628_acf6));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, CTRL_OFS, '0, rd, er);
      chk(rd, 32'h0000_aaa0);
      apb(1'b0, ETYPE_OFS, '0, rd, er);
      chk(rd, 32'h0000_0600);
      apb(1'b0, 12'h014, '0, rd, er);
      chk({rd[30:0], er}, 32'h0000_0001);
      for (int it = 0; it < 250; it++)
      begin
         c = ctrl_s'(18'($urandom));
         lo = 16'($urandom);
         sp = {lo + 16'($urandom % 64), lo};
         lo = 16'($urandom);
         dp = {lo + 16'($urandom % 64), lo};
         do
            et = 16'($urandom);
         while (et < 16'h0600 || et == 16'h0800 || et == 16'h0806 ||
                et == 16'h86dd);
         if (it == 0)
            et = 16'h0600;
         apb(1'b1, CTRL_OFS, {14'h0000, c}, rd, er);
         apb(1'b1, SPORT_OFS, sp, rd, er);
         apb(1'b1, DPORT_OFS, dp, rd, er);
         apb(1'b1, ETYPE_OFS, {16'h0000, et}, rd, er);
         apb(1'b1, ETYPE_OFS, 32'h0000_05ff, rd, er);
         chk(32'(er), 32'h0000_0001);
         apb(1'b0, ETYPE_OFS, '0, rd, er);
         chk(rd, {16'h0000, et});
         for (int k = 0; k < 4; k++)
         begin
            f = frame_s'(56'({$urandom, $urandom}));
            f.sport = pick(sp);
            f.dport = pick(dp);
            f.is_l4 = ($urandom % 8) != 0;
            if ($urandom % 2)
               f.etype = et;
            for (int i = 0; i < N_FLAGS; i++)
               f.tcp_flags[i] = (($urandom % 6) == 0) ^
                                (c.flags[i] == FLAG_ONE);
            @(posedge clk);
            send <= 1'b1;
            send_frame <= f;
            exp_q.push_back(model(c, sp, dp, et, f));
         end
         @(posedge clk);
         send <= 1'b0;
         n = 0;
         while (exp_q.size() != 0 && n < 20)
         begin
            @(posedge clk);
            n++;
         end
      end
      test_done();
   end
endmodule

`default_nettype wire
